// [design/mmd_pkg.sv]
/*
 * Constants for the memory map address decoder: address ranges, target codes
 * and register word addresses.
 * Assumes a 16-bit program and data address space issued by the processor core.
 */
package mmd_pkg;

    typedef enum logic [3:0] {
        MMD_TGT_NONE     = 4'h0,
        MMD_TGT_FLASH    = 4'h1,
        MMD_TGT_EXT_PROG = 4'h2,
        MMD_TGT_RAM0     = 4'h3,
        MMD_TGT_RAM1     = 4'h4,
        MMD_TGT_RAM2     = 4'h5,
        MMD_TGT_FRAME1   = 4'h6,
        MMD_TGT_FRAME2   = 4'h7,
        MMD_TGT_EXT_DATA = 4'h8,
        MMD_TGT_EXT_IO   = 4'h9,
        MMD_TGT_CORE_REG = 4'hA
    } mmd_target_t;

    localparam int          MMD_NUM_TGT    = 11;

    // Program space.
    localparam logic [15:0] MMD_P_FLASH_HI = 16'h1FFF;
    localparam logic [15:0] MMD_P_B0_ALIAS = 16'hFE00;
    localparam logic [15:0] MMD_P_B0_HOME  = 16'hFF00;
    localparam logic [15:0] MMD_P_B0_END   = 16'hFFFF;

    // Data space.
    localparam logic [15:0] MMD_D_RSVD_LO  = 16'h0000;
    localparam logic [15:0] MMD_D_RSVD_HI  = 16'h0003;
    localparam logic [15:0] MMD_D_IMR_ADR  = 16'h0004;
    localparam logic [15:0] MMD_D_GMA_ADR  = 16'h0005;
    localparam logic [15:0] MMD_D_IFR_ADR  = 16'h0006;
    localparam logic [15:0] MMD_D_MMR_HI   = 16'h005F;
    localparam logic [15:0] MMD_D_B2_LO    = 16'h0060;
    localparam logic [15:0] MMD_D_B2_HI    = 16'h007F;
    localparam logic [15:0] MMD_D_B0A_LO   = 16'h0100;
    localparam logic [15:0] MMD_D_B0A_HI   = 16'h01FF;
    localparam logic [15:0] MMD_D_B0_LO    = 16'h0200;
    localparam logic [15:0] MMD_D_B0_HI    = 16'h02FF;
    localparam logic [15:0] MMD_D_B1_LO    = 16'h0300;
    localparam logic [15:0] MMD_D_B1A_HI   = 16'h04FF;
    localparam logic [15:0] MMD_D_F1_LO    = 16'h7000;
    localparam logic [15:0] MMD_D_F1_HI    = 16'h73FF;
    localparam logic [15:0] MMD_D_F2_LO    = 16'h7400;
    localparam logic [15:0] MMD_D_F2_HI    = 16'h743F;
    localparam logic [15:0] MMD_D_EXT_LO   = 16'h8000;

    // Sub-ranges inside the peripheral frames.
    localparam logic [15:0] MMD_F1_SYS_LO  = 16'h7010;
    localparam logic [15:0] MMD_F1_WD_LO   = 16'h7020;
    localparam logic [15:0] MMD_F1_WD_HI   = 16'h702F;
    localparam logic [15:0] MMD_F1_SCI_HI  = 16'h705F;
    localparam logic [15:0] MMD_F1_XI_LO   = 16'h7070;
    localparam logic [15:0] MMD_F1_XI_HI   = 16'h707F;
    localparam logic [15:0] MMD_F1_IO_LO   = 16'h7090;
    localparam logic [15:0] MMD_F1_IO_HI   = 16'h709F;
    localparam logic [15:0] MMD_F1_CANC_LO = 16'h7100;
    localparam logic [15:0] MMD_F1_CANC_HI = 16'h710E;
    localparam logic [15:0] MMD_F1_CANM_LO = 16'h7200;
    localparam logic [15:0] MMD_F1_CANM_HI = 16'h722F;
    localparam logic [15:0] MMD_F2_TMR_HI  = 16'h7408;
    localparam logic [15:0] MMD_F2_CMP_LO  = 16'h7411;
    localparam logic [15:0] MMD_F2_CMP_HI  = 16'h7419;
    localparam logic [15:0] MMD_F2_CAP_LO  = 16'h7420;
    localparam logic [15:0] MMD_F2_CAP_HI  = 16'h7429;
    localparam logic [15:0] MMD_F2_INT_LO  = 16'h742C;
    localparam logic [15:0] MMD_F2_INT_HI  = 16'h7431;

    // Core register reset values.
    localparam logic [15:0] MMD_IMR_RST    = 16'h0000;
    localparam logic [15:0] MMD_GMA_RST    = 16'h0000;
    localparam logic [15:0] MMD_IFR_RST    = 16'h0000;

endpackage : mmd_pkg

// [design/mmd_core_regs.sv]
/*
 * Core register trio at data words 0004..0006: interrupt mask, global memory
 * allocation and interrupt flags.
 * Assumes the decoder qualifies i_sel; flags are set by hardware, cleared by
 * writing one, and a set in the same cycle as a clear wins.
 */
`timescale 1ns/1ps
`default_nettype none
module mmd_core_regs (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_sel,
    input  wire logic        i_wr,
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic [15:0] i_flag_set,
    output logic      [15:0] o_rdata,
    output logic      [15:0] o_interrupt_mask,
    output logic      [15:0] o_global_memory_allocation,
    output logic      [15:0] o_interrupt_flags
);
    logic [15:0] imr_reg;
    logic [15:0] gma_reg;
    logic [15:0] ifr_reg;
    logic [15:0] ifr_next;
    logic [15:0] rdata_reg;
    logic        hit_imr;
    logic        hit_gma;
    logic        hit_ifr;

    assign hit_imr  = i_sel && (i_addr == mmd_pkg::MMD_D_IMR_ADR);
    assign hit_gma  = i_sel && (i_addr == mmd_pkg::MMD_D_GMA_ADR);
    assign hit_ifr  = i_sel && (i_addr == mmd_pkg::MMD_D_IFR_ADR);
    // Write-one clears, but a new event in the same cycle is kept.
    assign ifr_next = (ifr_reg & ~((hit_ifr && i_wr) ? i_wdata : 16'h0000)) | i_flag_set;

    // Register storage and registered read data.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            imr_reg   <= mmd_pkg::MMD_IMR_RST;
            gma_reg   <= mmd_pkg::MMD_GMA_RST;
            ifr_reg   <= mmd_pkg::MMD_IFR_RST;
            rdata_reg <= 16'h0000;
        end else begin
            if (hit_imr && i_wr) imr_reg <= i_wdata;
            if (hit_gma && i_wr) gma_reg <= i_wdata;
            ifr_reg   <= ifr_next;
            rdata_reg <= hit_imr ? imr_reg : hit_gma ? gma_reg : hit_ifr ? ifr_reg : 16'h0000;
        end
    end

    assign o_rdata                    = rdata_reg;
    assign o_interrupt_mask           = imr_reg;
    assign o_global_memory_allocation = gma_reg;
    assign o_interrupt_flags          = ifr_reg;
endmodule : mmd_core_regs
`default_nettype wire

// [design/mmd_decoder.sv]
/*
 * Memory map address decoder: classifies each program or data access of the
 * core into one target select, a reserved flag or an illegal flag, and
 * raises a non-maskable interrupt request on illegal accesses.
 * Assumes the core presents one access per cycle with i_req high; the mode pin
 * is sampled here, while the placement bit is used as it arrives, unsampled.
 */
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder #(
    parameter bit P_FULL_VARIANT = 1'b1
) (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_req,
    input  wire logic        i_prog_space,
    input  wire logic        i_io_space,
    input  wire logic        i_wr,
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_block_zero_placement_bit,
    input  wire logic        i_microcomputer_mode_pin,
    input  wire logic [15:0] i_flag_set,
    output logic      [10:0] o_target_sel,
    output logic      [15:0] o_target_addr,
    output logic      [3:0]  o_frame_unit,
    output logic             o_reserved,
    output logic             o_illegal,
    output logic             o_nmi_req,
    output logic      [15:0] o_core_rdata,
    output logic      [15:0] o_interrupt_mask,
    output logic      [15:0] o_global_memory_allocation,
    output logic      [15:0] o_interrupt_flags
);
    typedef mmd_pkg::mmd_target_t mmd_tgt_t;

    // Mode pin from outside: three stages, change taken when stages two and three agree.
    logic [2:0]  mode_sync_reg;
    logic        mode_reg;
    logic        mode_next;

    logic        in;
    logic        a_flash;
    logic        p_b0_alias;
    logic        p_b0_home;
    logic        d_rsvd_low;
    logic        d_core;
    logic        d_mmr_other;
    logic        d_b2;
    logic        d_b0_alias;
    logic        d_b0_home;
    logic        d_b1;
    logic        d_b1_alias;
    logic        d_f1;
    logic        d_f2;
    logic        d_ext;
    logic        f1_hole;
    logic        f2_hole;
    mmd_tgt_t    tgt;
    logic        rsvd;
    logic        illg;
    logic [15:0] taddr;
    logic [3:0]  unit;

    logic [10:0] sel_reg;
    logic [15:0] taddr_reg;
    logic [3:0]  unit_reg;
    logic        rsvd_reg;
    logic        illg_reg;
    logic        nmi_reg;

    assign mode_next = (mode_sync_reg[1] == mode_sync_reg[2]) ? mode_sync_reg[2] : mode_reg;

    // Mode pin synchroniser.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_sync_reg <= 3'h0;
            mode_reg      <= 1'b0;
        end else begin
            mode_sync_reg <= {mode_sync_reg[1:0], i_microcomputer_mode_pin};
            mode_reg      <= mode_next;
        end
    end

    // Program space ranges.
    assign a_flash    = i_addr <= mmd_pkg::MMD_P_FLASH_HI;
    assign p_b0_alias = i_addr >= mmd_pkg::MMD_P_B0_ALIAS && i_addr < mmd_pkg::MMD_P_B0_HOME;
    assign p_b0_home  = i_addr >= mmd_pkg::MMD_P_B0_HOME;

    // Data space ranges.
    assign d_rsvd_low  = i_addr <= mmd_pkg::MMD_D_RSVD_HI;
    assign d_core      = i_addr >= mmd_pkg::MMD_D_IMR_ADR && i_addr <= mmd_pkg::MMD_D_IFR_ADR;
    assign d_mmr_other = i_addr > mmd_pkg::MMD_D_IFR_ADR && i_addr <= mmd_pkg::MMD_D_MMR_HI;
    assign d_b2        = i_addr >= mmd_pkg::MMD_D_B2_LO && i_addr <= mmd_pkg::MMD_D_B2_HI;
    assign d_b0_alias  = i_addr >= mmd_pkg::MMD_D_B0A_LO && i_addr <= mmd_pkg::MMD_D_B0A_HI;
    assign d_b0_home   = i_addr >= mmd_pkg::MMD_D_B0_LO && i_addr <= mmd_pkg::MMD_D_B0_HI;
    assign d_b1        = i_addr >= mmd_pkg::MMD_D_B1_LO && i_addr < mmd_pkg::MMD_D_B1_LO + 16'h0100;
    assign d_b1_alias  = i_addr >= mmd_pkg::MMD_D_B1_LO + 16'h0100
                         && i_addr <= mmd_pkg::MMD_D_B1A_HI;
    assign d_f1        = i_addr >= mmd_pkg::MMD_D_F1_LO && i_addr <= mmd_pkg::MMD_D_F1_HI;
    assign d_f2        = i_addr >= mmd_pkg::MMD_D_F2_LO && i_addr <= mmd_pkg::MMD_D_F2_HI;
    assign d_ext       = i_addr >= mmd_pkg::MMD_D_EXT_LO;

    // Frame sub-decode: unit code inside each frame, and holes that are illegal.
    always_comb begin
        unit    = 4'h0;
        f1_hole = 1'b1;
        f2_hole = 1'b1;
        if (i_addr >= mmd_pkg::MMD_F1_SYS_LO && i_addr < mmd_pkg::MMD_F1_WD_LO) begin
            unit = 4'h1;
            f1_hole = 1'b0;
        end else if (i_addr >= mmd_pkg::MMD_F1_WD_LO && i_addr <= mmd_pkg::MMD_F1_WD_HI) begin
            unit = 4'h2;
            f1_hole = 1'b0;
        end else if (i_addr > mmd_pkg::MMD_F1_WD_HI && i_addr <= mmd_pkg::MMD_F1_SCI_HI) begin
            unit = {1'b0, i_addr[6:4]};  // Converter 3, serial peripheral 4, serial comms 5.
            f1_hole = 1'b0;
        end else if (i_addr >= mmd_pkg::MMD_F1_XI_LO && i_addr <= mmd_pkg::MMD_F1_XI_HI) begin
            unit = 4'h6;
            f1_hole = 1'b0;
        end else if (i_addr >= mmd_pkg::MMD_F1_IO_LO && i_addr <= mmd_pkg::MMD_F1_IO_HI) begin
            unit = 4'h7;
            f1_hole = 1'b0;
        end else if (i_addr >= mmd_pkg::MMD_F1_CANC_LO && i_addr <= mmd_pkg::MMD_F1_CANC_HI) begin
            unit = 4'h8;
            f1_hole = 1'b0;
        end else if (i_addr >= mmd_pkg::MMD_F1_CANM_LO && i_addr <= mmd_pkg::MMD_F1_CANM_HI) begin
            unit = 4'h9;
            f1_hole = 1'b0;
        end else if (i_addr >= mmd_pkg::MMD_D_F2_LO && i_addr <= mmd_pkg::MMD_F2_TMR_HI) begin
            unit = 4'hA;
            f2_hole = 1'b0;
        end else if (i_addr >= mmd_pkg::MMD_F2_CMP_LO && i_addr <= mmd_pkg::MMD_F2_CMP_HI) begin
            unit = 4'hB;
            f2_hole = 1'b0;
        end else if (i_addr >= mmd_pkg::MMD_F2_CAP_LO && i_addr <= mmd_pkg::MMD_F2_CAP_HI) begin
            unit = 4'hC;
            f2_hole = 1'b0;
        end else if (i_addr >= mmd_pkg::MMD_F2_INT_LO && i_addr <= mmd_pkg::MMD_F2_INT_HI) begin
            unit = 4'hD;
            f2_hole = 1'b0;
        end
    end

    // Target classification. Priority order mirrors the map; exactly one outcome.
    always_comb begin
        tgt   = mmd_pkg::MMD_TGT_NONE;
        rsvd  = 1'b0;
        illg  = 1'b0;
        taddr = i_addr;
        if (i_io_space) begin
            if (P_FULL_VARIANT) tgt = mmd_pkg::MMD_TGT_EXT_IO;
            else illg = 1'b1;
        end else if (i_prog_space) begin
            if (a_flash) begin
                if (!mode_reg) tgt = mmd_pkg::MMD_TGT_FLASH;
                else if (P_FULL_VARIANT) tgt = mmd_pkg::MMD_TGT_EXT_PROG;
                else illg = 1'b1;
            end else if (i_block_zero_placement_bit && (p_b0_alias || p_b0_home)) begin
                tgt   = mmd_pkg::MMD_TGT_RAM0;
                taddr = {8'h00, i_addr[7:0]};
            end else if (P_FULL_VARIANT) begin
                tgt = mmd_pkg::MMD_TGT_EXT_PROG;
            end else begin
                illg = 1'b1;
            end
        end else if (d_rsvd_low || d_mmr_other) begin
            rsvd = 1'b1;
        end else if (d_core) begin
            tgt = mmd_pkg::MMD_TGT_CORE_REG;
        end else if (d_b2) begin
            tgt   = mmd_pkg::MMD_TGT_RAM2;
            taddr = {11'h000, i_addr[4:0]};
        end else if (d_b0_alias || d_b0_home) begin
            if (!i_block_zero_placement_bit) begin
                tgt   = mmd_pkg::MMD_TGT_RAM0;
                taddr = {8'h00, i_addr[7:0]};
            end else begin
                rsvd = 1'b1;
            end
        end else if (d_b1 || d_b1_alias) begin
            tgt   = mmd_pkg::MMD_TGT_RAM1;
            taddr = {8'h00, i_addr[7:0]};
        end else if (d_f1) begin
            if (f1_hole) illg = 1'b1;
            else tgt = mmd_pkg::MMD_TGT_FRAME1;
        end else if (d_f2) begin
            if (f2_hole) illg = 1'b1;
            else tgt = mmd_pkg::MMD_TGT_FRAME2;
        end else if (d_ext) begin
            if (P_FULL_VARIANT) tgt = mmd_pkg::MMD_TGT_EXT_DATA;
            else illg = 1'b1;
        end else begin
            illg = 1'b1;
        end
    end

    assign in = i_req;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sel_reg   <= 11'h000;
            taddr_reg <= 16'h0000;
            unit_reg  <= 4'h0;
            rsvd_reg  <= 1'b0;
            illg_reg  <= 1'b0;
            nmi_reg   <= 1'b0;
        end else begin
            sel_reg   <= (in && tgt != mmd_pkg::MMD_TGT_NONE) ? 11'(11'h001 << tgt) : 11'h000;
            taddr_reg <= taddr;
            unit_reg  <= (in && (d_f1 || d_f2) && !i_prog_space && !i_io_space) ? unit : 4'h0;
            rsvd_reg  <= in && rsvd;
            illg_reg  <= in && illg;
            nmi_reg   <= in && illg;
        end
    end

    // Core register trio lives inside the decoder.
    mmd_core_regs u_core_regs (
        .i_clk                      (i_clk),
        .i_nrst                     (i_nrst),
        .i_sel                      (in && tgt == mmd_pkg::MMD_TGT_CORE_REG),
        .i_wr                       (i_wr),
        .i_addr                     (i_addr),
        .i_wdata                    (i_wdata),
        .i_flag_set                 (i_flag_set),
        .o_rdata                    (o_core_rdata),
        .o_interrupt_mask           (o_interrupt_mask),
        .o_global_memory_allocation (o_global_memory_allocation),
        .o_interrupt_flags          (o_interrupt_flags)
    );

    assign o_target_sel  = sel_reg;
    assign o_target_addr = taddr_reg;
    assign o_frame_unit  = unit_reg;
    assign o_reserved    = rsvd_reg;
    assign o_illegal     = illg_reg;
    assign o_nmi_req     = nmi_reg;
endmodule : mmd_decoder
`default_nettype wire

// [tb/mmd_decoder_checker.sv]
/*
 * Port assertions for the memory map decoder.
 * Assumes one clock domain and the asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder_checker #(
    parameter bit P_FULL_VARIANT = 1'b1
) (
    input wire logic        i_clk,
    input wire logic        i_nrst,
    input wire logic        i_req,
    input wire logic        i_prog_space,
    input wire logic        i_io_space,
    input wire logic        i_wr,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_block_zero_placement_bit,
    input wire logic [10:0] o_target_sel,
    input wire logic [15:0] o_target_addr,
    input wire logic [3:0]  o_frame_unit,
    input wire logic        o_illegal,
    input wire logic        o_nmi_req,
    input wire logic [15:0] o_interrupt_mask
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    // A data access is one with neither space line high.
    wire d_acc = i_req && !i_prog_space && !i_io_space;

    // Request steps that lead to a frame answer one cycle later.
    sequence s_wd_hit;
        d_acc && i_addr inside {[16'h7020:16'h702F]};
    endsequence
    sequence s_wd_answer;
        o_target_sel == 11'h040 && o_frame_unit == 4'h2;
    endsequence

    a_sel_one_hot: assert property ($onehot0(o_target_sel))
        else $error("more than one target select");
    a_illegal_no_sel: assert property (o_illegal |-> o_target_sel == 11'h000 && o_nmi_req)
        else $error("illegal access with select or no nmi");
    a_illegal_nmi: assert property (d_acc && i_addr inside {[16'h7440:16'h7FFF]} |=> o_nmi_req)
        else $error("illegal frame gap gave no nmi");
    a_ext_data_route: assert property (d_acc && i_addr[15]
        |=> (P_FULL_VARIANT ? o_target_sel == 11'h100 : o_illegal)) else $error("external data");
    a_wd_frame: assert property (s_wd_hit |=> s_wd_answer)
        else $error("watchdog range not decoded");
    a_cmp_frame: assert property (d_acc && i_addr inside {[16'h7411:16'h7419]}
        |=> o_target_sel == 11'h080 && o_frame_unit == 4'hB) else $error("compare range");
    a_cap_frame: assert property (d_acc && i_addr inside {[16'h7420:16'h7429]}
        |=> o_frame_unit == 4'hC) else $error("capture range");
    a_ram1_alias: assert property (d_acc && i_addr inside {[16'h0300:16'h04FF]}
        |=> o_target_sel == 11'h010 && o_target_addr[7:0] == $past(i_addr[7:0]))
        else $error("ram block one alias");
    a_ram0_data: assert property (d_acc && !i_block_zero_placement_bit
        && i_addr inside {[16'h0100:16'h02FF]} |=> o_target_sel == 11'h008) else $error("ram0 data");
    a_ram0_prog: assert property (i_req && i_prog_space && !i_io_space
        && i_block_zero_placement_bit && i_addr >= 16'hFE00 |=> o_target_sel == 11'h008)
        else $error("ram0 program alias");
    a_mask_write: assert property (d_acc && i_wr && i_addr == 16'h0004
        |=> o_interrupt_mask == $past(i_wdata)) else $error("mask write lost");
    a_idle_quiet: assert property (!i_req |=> o_target_sel == 11'h000 && !o_illegal)
        else $error("select without request");
endmodule : mmd_decoder_checker

bind mmd_decoder mmd_decoder_checker #(.P_FULL_VARIANT(P_FULL_VARIANT)) u_chk (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req), .i_prog_space(i_prog_space),
    .i_io_space(i_io_space), .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_block_zero_placement_bit(i_block_zero_placement_bit), .o_target_sel(o_target_sel),
    .o_target_addr(o_target_addr), .o_frame_unit(o_frame_unit), .o_illegal(o_illegal),
    .o_nmi_req(o_nmi_req), .o_interrupt_mask(o_interrupt_mask));
`default_nettype wire

// [tb/mmd_core_model.sv]
/*
 * Processor core model: issues one program, data or I/O access per call.
 * Assumes the decoder takes a request at the rising edge with request high.
 */
`timescale 1ns/1ps
`default_nettype none
module mmd_core_model (
    input  wire logic        i_clk,
    output var  logic        o_req,
    output var  logic        o_prog_space,
    output var  logic        o_io_space,
    output var  logic        o_wr,
    output var  logic [15:0] o_addr,
    output var  logic [15:0] o_wdata
);
    // Quiet bus at time zero.
    initial begin
        {o_req, o_prog_space, o_io_space, o_wr} = 4'h0;
        o_addr = 16'h0000;
        o_wdata = 16'h0000;
    end

    // Released address and data lines show the inverse so a stale value never decodes by luck.
    task automatic access(input logic [1:0] sp, input logic w,
                          input logic [15:0] a, input logic [15:0] d);
        @(posedge i_clk);
        #1;
        {o_req, o_io_space, o_prog_space, o_wr} = {1'b1, sp, w};
        o_addr = a;
        o_wdata = d;
        @(posedge i_clk);
        #1;
        {o_req, o_wr} = 2'b00;
        o_addr = ~a;
        o_wdata = ~d;
    endtask : access
endmodule : mmd_core_model
`default_nettype wire

// [tb/tb_mmd_decoder.sv]
/*
 * Self-checking bench: one core model feeds a full and a reduced decoder.
 * Assumes registered answers one cycle after each taken request.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_mmd_decoder;
    logic        i_clk, i_nrst, block_zero_placement_bit, mode;
    logic [15:0] flag_set;
    wire         req, ps, io, wr, rsv, nmi, ill;
    wire  [15:0] addr, wdata, taddr, rdata, interrupt_mask, gma, interrupt_flags;
    wire  [10:0] sel_f, sel_r;
    wire  [3:0]  unit;
    int          mismatches = 0;
    int          cmp_count = 0;

    mmd_core_model u_core (.i_clk(i_clk), .o_req(req), .o_prog_space(ps), .o_io_space(io),
        .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
    mmd_decoder #(.P_FULL_VARIANT(1'b1)) u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(req),
        .i_prog_space(ps), .i_io_space(io), .i_wr(wr), .i_addr(addr), .i_wdata(wdata),
        .i_block_zero_placement_bit(block_zero_placement_bit), .i_microcomputer_mode_pin(mode),
        .i_flag_set(flag_set), .o_target_sel(sel_f), .o_target_addr(taddr),
        .o_frame_unit(unit), .o_reserved(rsv), .o_illegal(ill), .o_nmi_req(nmi),
        .o_core_rdata(rdata), .o_interrupt_mask(interrupt_mask), .o_global_memory_allocation(gma),
        .o_interrupt_flags(interrupt_flags));
    mmd_decoder #(.P_FULL_VARIANT(1'b0)) u_dut_red (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_req(req), .i_prog_space(ps), .i_io_space(io), .i_wr(wr), .i_addr(addr),
        .i_wdata(wdata), .i_block_zero_placement_bit(block_zero_placement_bit), .i_microcomputer_mode_pin(mode),
        .i_flag_set(flag_set), .o_target_sel(sel_r), .o_target_addr(), .o_frame_unit(),
        .o_reserved(), .o_illegal(), .o_nmi_req(), .o_core_rdata(), .o_interrupt_mask(),
        .o_global_memory_allocation(), .o_interrupt_flags());

    // Free-running 50 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    task automatic print_verdict();
        if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Codes 1..A are targets, 0 means reserved, F means illegal.
    function automatic logic [10:0] sel_of(input logic [3:0] c);
        return (c >= 4'h1 && c <= 4'hA) ? (11'h001 << c) : 11'h000;
    endfunction : sel_of

    // One read access with the expected answer of both variants.
    task automatic probe(input logic [1:0] sp, input logic c, input logic [15:0] a,
                         input logic [3:0] ef, input logic [3:0] er, input logic [3:0] u);
        block_zero_placement_bit = c;
        u_core.access(sp, 1'b0, a, 16'h0000);
        chk("sel_full", {5'h00, sel_of(ef)}, {5'h00, sel_f});
        chk("sel_reduced", {5'h00, sel_of(er)}, {5'h00, sel_r});
        chk("nmi", {15'h0000, ef == 4'hF}, {15'h0000, nmi});
        chk("illegal", {15'h0000, ef == 4'hF}, {15'h0000, ill});
        chk("reserved", {15'h0000, ef == 4'h0}, {15'h0000, rsv});
        chk("unit", {12'h000, u}, {12'h000, unit});
        if (ef == 4'h3 || ef == 4'h4) chk("local_addr", {8'h00, a[7:0]}, taddr);
        if (ef == 4'h5) chk("local_addr_b2", {11'h000, a[4:0]}, taddr);
    endtask : probe

    // Hang guard well beyond the length of the sequence.
    initial begin
        repeat (3000) @(posedge i_clk);
        mismatches++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        {i_nrst, block_zero_placement_bit, mode} = 3'b000;
        flag_set = 16'h0000;
        repeat (4) @(posedge i_clk);
        #1 i_nrst = 1'b1;
        chk("mask_rst", 16'h0000, interrupt_mask);
        chk("gma_rst", 16'h0000, gma);
        chk("flags_rst", 16'h0000, interrupt_flags);
        probe(2'b01, 1'b1, 16'hFE05, 4'h3, 4'h3, 4'h0);
        probe(2'b01, 1'b1, 16'hFF05, 4'h3, 4'h3, 4'h0);
        probe(2'b00, 1'b0, 16'h0105, 4'h3, 4'h3, 4'h0);
        probe(2'b00, 1'b0, 16'h0205, 4'h3, 4'h3, 4'h0);
        probe(2'b00, 1'b1, 16'h0105, 4'h0, 4'h0, 4'h0);
        probe(2'b00, 1'b0, 16'h0305, 4'h4, 4'h4, 4'h0);
        probe(2'b00, 1'b0, 16'h0405, 4'h4, 4'h4, 4'h0);
        probe(2'b01, 1'b0, 16'h0010, 4'h1, 4'h1, 4'h0);
        probe(2'b01, 1'b0, 16'h2000, 4'h2, 4'hF, 4'h0);
        probe(2'b00, 1'b0, 16'h7440, 4'hF, 4'hF, 4'h0);
        probe(2'b00, 1'b0, 16'h7FFF, 4'hF, 4'hF, 4'h0);
        probe(2'b00, 1'b0, 16'h8000, 4'h8, 4'hF, 4'h0);
        probe(2'b00, 1'b0, 16'hFFFF, 4'h8, 4'hF, 4'h0);
        probe(2'b10, 1'b0, 16'h0010, 4'h9, 4'hF, 4'h0);
        probe(2'b00, 1'b0, 16'h7020, 4'h6, 4'h6, 4'h2);
        probe(2'b00, 1'b0, 16'h7030, 4'h6, 4'h6, 4'h3);
        probe(2'b00, 1'b0, 16'h7050, 4'h6, 4'h6, 4'h5);
        probe(2'b00, 1'b0, 16'h7000, 4'hF, 4'hF, 4'h0);
        probe(2'b00, 1'b0, 16'h710E, 4'h6, 4'h6, 4'h8);
        probe(2'b00, 1'b0, 16'h722F, 4'h6, 4'h6, 4'h9);
        probe(2'b00, 1'b0, 16'h7400, 4'h7, 4'h7, 4'hA);
        probe(2'b00, 1'b0, 16'h7411, 4'h7, 4'h7, 4'hB);
        probe(2'b00, 1'b0, 16'h7429, 4'h7, 4'h7, 4'hC);
        probe(2'b00, 1'b0, 16'h0060, 4'h5, 4'h5, 4'h0);
        probe(2'b00, 1'b0, 16'h0080, 4'hF, 4'hF, 4'h0);
        probe(2'b00, 1'b0, 16'h0006, 4'hA, 4'hA, 4'h0);
        // Mode pin passes a synchroniser, so let it settle first.
        mode = 1'b1;
        repeat (5) @(posedge i_clk);
        probe(2'b01, 1'b0, 16'h0010, 4'h2, 4'hF, 4'h0);
        u_core.access(2'b00, 1'b1, 16'h0004, 16'hA5A5);
        chk("mask", 16'hA5A5, interrupt_mask);
        u_core.access(2'b00, 1'b1, 16'h0005, 16'h1234);
        chk("gma", 16'h1234, gma);
        u_core.access(2'b00, 1'b0, 16'h0005, 16'h0000);
        chk("gma_read", 16'h1234, rdata);
        @(posedge i_clk);
        #1 flag_set = 16'h0008;
        @(posedge i_clk);
        #1 flag_set = 16'h0000;
        chk("flag_set", 16'h0008, interrupt_flags);
        u_core.access(2'b00, 1'b1, 16'h0006, 16'h0008);
        chk("flag_clear", 16'h0000, interrupt_flags);
        // A new event in the cycle of its clear must survive the clear.
        flag_set = 16'h0010;
        u_core.access(2'b00, 1'b1, 16'h0006, 16'h0010);
        flag_set = 16'h0000;
        chk("flag_set_wins", 16'h0010, interrupt_flags);
        print_verdict();
    end
endmodule : tb_mmd_decoder
`default_nettype wire
